// *** hdl/nvm_protect_pkg.sv ***
// Constants, field positions and carrier types for the flash
// protection, option and command object register bank.
// Assumes a byte-wide register port and one 250 MHz clock.
//
// Notes on behaviour
// - size only grows; disable only falls
// - disable clear protects range; set protects none
// - reset sequence loads protection byte from configuration
// - double-bit fault forces full protection
// - protected program or erase sets violation flag
// - block erase refused while anything protected
// - range starts at base, 32 bytes per step
// - option register readable, writes ignored
// - reset sequence loads all option bits
// - double-bit fault sets all option bits
// - reserved test register reads zero, ignores writes
// - six 16-bit words, byte-wide access
// - writing one to complete flag launches
// - fields locked while busy; done sets flag
// - results valid only after flag returns
// - word zero code and address high byte
// - busy flag blocks command array writes
package nvm_protect_pkg;

   // ------------------------------------------------------------
   // register offsets on the byte port
   // ------------------------------------------------------------
   localparam logic [7:0] OFF_INDEX = 8'h02;
   localparam logic [7:0] OFF_STATUS = 8'h06;
   localparam logic [7:0] OFF_EEPROT = 8'h09;
   localparam logic [7:0] OFF_OPTION = 8'h0A;
   localparam logic [7:0] OFF_RSVD = 8'h0B;
   localparam logic [7:0] OFF_CMD_HI = 8'h0C;
   localparam logic [7:0] OFF_CMD_LO = 8'h0D;
   localparam logic [7:0] OFF_IRQ_ST = 8'h0E;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h0F;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int ST_CCF_BIT = 7;
   localparam int ST_VIOL_BIT = 5;
   localparam int PROT_DIS_BIT = 7;
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_VIOL_BIT = 1;

   // ------------------------------------------------------------
   // reset and fault values
   // ------------------------------------------------------------
   localparam logic [3:0] PROT_SIZE_FULL = 4'hF;
   localparam logic [7:0] OPT_ALL_SET = 8'hFF;
   localparam logic [2:0] CMD_WORDS = 3'h6;

   // configuration field addresses fetched by the reset loader
   localparam logic [23:0] CFG_PROT_ADDR = 24'hFF_FE0D;
   localparam logic [23:0] CFG_OPT_ADDR = 24'hFF_FE0E;

   // ------------------------------------------------------------
   // protected eeprom window
   // ------------------------------------------------------------
   localparam logic [23:0] EE_BASE = 24'h10_0000;
   localparam int EE_STEP_SHIFT = 5;

   // command words handed to the memory controller
   typedef struct packed {
      logic [7:0] code;
      logic [23:0] addr;
      logic [3:0][15:0] data;
      logic [2:0] words;
   } cmd_s;

   // whole register state of the bank
   typedef struct packed {
      logic ccf;
      logic viol;
      logic [2:0] idx;
      logic protDis;
      logic [3:0] protSize;
      logic [7:0] opt;
      logic [5:0][15:0] words;
      logic [1:0] irqSt;
      logic [1:0] irqMask;
      logic [7:0] rdData;
      logic launch;
   } state_s;

endpackage

// *** hdl/nvm_protect_cmd_regs.sv ***
// Protection, option, reserved and command object registers
// of an embedded flash module, with launch handshake.
// Assumes a same-clock reset loader and memory controller.
//
// Local design decision: strobed register access.
`timescale 1ns/1ns

module nvm_protect_cmd_regs
(
   // clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // register port
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdata,
   // reset loader of nonvolatile bytes
   input wire logic nvLoad,
   input wire logic [7:0] nvProtByte,
   input wire logic nvProtDbe,
   input wire logic [7:0] nvOptByte,
   input wire logic nvOptDbe,
   // memory controller command side
   output logic cmdLaunch,
   output nvm_protect_pkg::cmd_s cmdOut,
   input wire logic cmdDone,
   input wire logic resWe,
   input wire logic [2:0] resIdx,
   input wire logic [15:0] resData,
   // protection check of a program or erase
   input wire logic chkValid,
   input wire logic [23:0] chkAddr,
   input wire logic chkBlkErase,
   output logic chkDenied,
   // option bits and interrupt
   output logic [7:0] optionBits,
   output logic irq
);

   // ------------------------------------------------------------
   // state and decode
   // ------------------------------------------------------------
   nvm_protect_pkg::state_s q; // registered state
   nvm_protect_pkg::state_s d; // next state
   logic [23:0] protEnd; // first address past the window
   logic [4:0] sizeP1; // size code plus one
   logic inRange; // check address inside window
   logic violEvt; // a denied check this cycle
   logic wrIdx; // write strobes per register
   logic wrStatus;
   logic wrProt;
   logic wrCmdHi;
   logic wrCmdLo;
   logic wrIrqSt;
   logic wrIrqMask;

   // ------------------------------------------------------------
   // protection window
   // ------------------------------------------------------------

   // window length is 32 bytes times code plus one
   always_comb
   begin
      sizeP1 = {1'b0, q.protSize} + 5'h1;
      protEnd = nvm_protect_pkg::EE_BASE
         + {14'h0, sizeP1, 5'h0};
      inRange = (chkAddr >= nvm_protect_pkg::EE_BASE)
         && (chkAddr < protEnd);
   end

   // a block erase hits whenever any sector is protected,
   // and with the disable bit clear at least one always is
   assign chkDenied = chkValid && !q.protDis
      && (chkBlkErase || inRange);
   assign violEvt = chkDenied;

   // ------------------------------------------------------------
   // write strobes
   // ------------------------------------------------------------

   // address decode for writes
   always_comb
   begin
      wrIdx = 1'b0;
      wrStatus = 1'b0;
      wrProt = 1'b0;
      wrCmdHi = 1'b0;
      wrCmdLo = 1'b0;
      wrIrqSt = 1'b0;
      wrIrqMask = 1'b0;
      if (!regWr)
      begin
         wrIdx = 1'b0;
      end
      else if (regAddr == nvm_protect_pkg::OFF_INDEX)
      begin
         wrIdx = 1'b1;
      end
      else if (regAddr == nvm_protect_pkg::OFF_STATUS)
      begin
         wrStatus = 1'b1;
      end
      else if (regAddr == nvm_protect_pkg::OFF_EEPROT)
      begin
         wrProt = 1'b1;
      end
      else if (regAddr == nvm_protect_pkg::OFF_CMD_HI)
      begin
         wrCmdHi = 1'b1;
      end
      else if (regAddr == nvm_protect_pkg::OFF_CMD_LO)
      begin
         wrCmdLo = 1'b1;
      end
      else if (regAddr == nvm_protect_pkg::OFF_IRQ_ST)
      begin
         wrIrqSt = 1'b1;
      end
      else if (regAddr == nvm_protect_pkg::OFF_IRQ_MASK)
      begin
         wrIrqMask = 1'b1;
      end
      // option and reserved writes fall through unused
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------

   always_comb
   begin
      d = q;
      d.launch = 1'b0;
      d.rdData = 8'h00;

      // word index is free to change at any time
      if (wrIdx)
      begin
         d.idx = regWdata[2:0];
      end

      // writing one to the complete flag launches; a one while
      // busy does nothing, so a command cannot be relaunched
      if (wrStatus && regWdata[nvm_protect_pkg::ST_CCF_BIT]
         && q.ccf)
      begin
         d.ccf = 1'b0;
         d.launch = 1'b1;
      end
      // controller finish brings the flag back
      if (cmdDone && !q.ccf)
      begin
         d.ccf = 1'b1;
      end

      // violation flag: write one clears, a new event wins
      if (wrStatus && regWdata[nvm_protect_pkg::ST_VIOL_BIT])
      begin
         d.viol = 1'b0;
      end
      if (violEvt)
      begin
         d.viol = 1'b1;
      end

      // protection may only be added, never removed
      if (wrProt)
      begin
         if (q.protDis && !regWdata[nvm_protect_pkg::PROT_DIS_BIT])
         begin
            d.protDis = 1'b0;
         end
         if (regWdata[3:0] > q.protSize)
         begin
            d.protSize = regWdata[3:0];
         end
      end

      // byte writes into the command array, only when idle and
      // only for the six real words
      if (q.ccf && (q.idx < nvm_protect_pkg::CMD_WORDS))
      begin
         if (wrCmdHi)
         begin
            d.words[q.idx][15:8] = regWdata;
         end
         if (wrCmdLo)
         begin
            d.words[q.idx][7:0] = regWdata;
         end
      end

      // controller returns results while still busy, so it
      // never races a software write
      if (resWe && !q.ccf && (resIdx < nvm_protect_pkg::CMD_WORDS))
      begin
         d.words[resIdx] = resData;
      end

      // interrupt status: write one clears, events win
      if (wrIrqSt)
      begin
         d.irqSt = q.irqSt & ~regWdata[1:0];
      end
      if (cmdDone && !q.ccf)
      begin
         d.irqSt[nvm_protect_pkg::IRQ_DONE_BIT] = 1'b1;
      end
      if (violEvt)
      begin
         d.irqSt[nvm_protect_pkg::IRQ_VIOL_BIT] = 1'b1;
      end
      if (wrIrqMask)
      begin
         d.irqMask = regWdata[1:0];
      end

      // reset loader has last word on the loaded bytes
      if (nvLoad)
      begin
         if (nvProtDbe)
         begin
            d.protDis = 1'b0;
            d.protSize = nvm_protect_pkg::PROT_SIZE_FULL;
         end
         else
         begin
            d.protDis = nvProtByte[nvm_protect_pkg::PROT_DIS_BIT];
            d.protSize = nvProtByte[3:0];
         end
         if (nvOptDbe)
         begin
            d.opt = nvm_protect_pkg::OPT_ALL_SET;
         end
         else
         begin
            d.opt = nvOptByte;
         end
      end

      // read data, answered one cycle after the strobe
      if (!regRd)
      begin
         d.rdData = 8'h00;
      end
      else if (regAddr == nvm_protect_pkg::OFF_INDEX)
      begin
         d.rdData = {5'h00, q.idx};
      end
      else if (regAddr == nvm_protect_pkg::OFF_STATUS)
      begin
         d.rdData = {q.ccf, 1'b0, q.viol, 5'h00};
      end
      else if (regAddr == nvm_protect_pkg::OFF_EEPROT)
      begin
         d.rdData = {q.protDis, 3'h0, q.protSize};
      end
      else if (regAddr == nvm_protect_pkg::OFF_OPTION)
      begin
         d.rdData = q.opt;
      end
      else if (regAddr == nvm_protect_pkg::OFF_RSVD)
      begin
         d.rdData = 8'h00;
      end
      else if (regAddr == nvm_protect_pkg::OFF_CMD_HI)
      begin
         if (q.idx < nvm_protect_pkg::CMD_WORDS)
         begin
            d.rdData = q.words[q.idx][15:8];
         end
      end
      else if (regAddr == nvm_protect_pkg::OFF_CMD_LO)
      begin
         if (q.idx < nvm_protect_pkg::CMD_WORDS)
         begin
            d.rdData = q.words[q.idx][7:0];
         end
      end
      else if (regAddr == nvm_protect_pkg::OFF_IRQ_ST)
      begin
         d.rdData = {6'h00, q.irqSt};
      end
      else if (regAddr == nvm_protect_pkg::OFF_IRQ_MASK)
      begin
         d.rdData = {6'h00, q.irqMask};
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------

   // until the loader runs the bank is fully protected, which
   // is the safe side if the loader never comes
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         q <= '0;
         q.ccf <= 1'b1;
         q.protSize <= nvm_protect_pkg::PROT_SIZE_FULL;
         q.opt <= nvm_protect_pkg::OPT_ALL_SET;
      end
      else
      begin
         q <= d;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------

   // command fields as laid out in the array
   always_comb
   begin
      cmdOut.code = q.words[0][15:8];
      cmdOut.addr = {q.words[0][7:0], q.words[1]};
      cmdOut.data = {q.words[5], q.words[4], q.words[3], q.words[2]};
      cmdOut.words = q.idx;
   end

   assign regRdata = q.rdData;
   assign cmdLaunch = q.launch;
   assign optionBits = q.opt;
   assign irq = |(q.irqSt & q.irqMask);

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);

   a_launch_clears_ccf: assert property (
      wrStatus && regWdata[nvm_protect_pkg::ST_CCF_BIT] && q.ccf
      |=> !q.ccf && cmdLaunch)
      else $error("launch did not clear the complete flag");

   a_busy_locks_array: assert property (
      (wrCmdHi || wrCmdLo) && !q.ccf && !resWe
      |=> q.words == $past(q.words))
      else $error("command array changed while busy");

   a_done_sets_ccf: assert property (
      cmdDone && !q.ccf |=> q.ccf
         && q.irqSt[nvm_protect_pkg::IRQ_DONE_BIT])
      else $error("done did not set the complete flag");

   a_size_never_drops: assert property (
      !nvLoad |=> q.protSize >= $past(q.protSize))
      else $error("protection size decreased");

   a_disable_stays_low: assert property (
      !nvLoad && !q.protDis |=> !q.protDis)
      else $error("protection disable bit rose");

   a_option_read_only: assert property (
      regWr && regAddr == nvm_protect_pkg::OFF_OPTION && !nvLoad
      |=> optionBits == $past(optionBits))
      else $error("option bits changed by a write");

   a_reserved_reads_zero: assert property (
      regRd && regAddr == nvm_protect_pkg::OFF_RSVD
      |=> regRdata == 8'h00)
      else $error("reserved register read nonzero");

   a_block_erase_refused: assert property (
      chkValid && chkBlkErase && !q.protDis |-> chkDenied)
      else $error("block erase allowed while protected");

   a_window_top_hit: assert property (
      chkValid && !q.protDis && chkAddr == protEnd - 24'h1
      ##0 chkAddr == nvm_protect_pkg::EE_BASE
         + ({19'h0, sizeP1} << nvm_protect_pkg::EE_STEP_SHIFT) - 24'h1
      |-> chkDenied ##1 q.viol)
      else $error("last protected byte not refused");

   a_disabled_open: assert property (
      chkValid && q.protDis |-> !chkDenied)
      else $error("denied while protection disabled");

   a_fault_full_prot: assert property (
      nvLoad && nvProtDbe |=> !q.protDis
         && q.protSize == nvm_protect_pkg::PROT_SIZE_FULL)
      else $error("fault did not force full protection");

   a_fault_opt_set: assert property (
      nvLoad && nvOptDbe |=> optionBits == nvm_protect_pkg::OPT_ALL_SET)
      else $error("fault did not set all option bits");

endmodule

// *** verification/testbench.sv ***
// Self-checking bench for the protection, option and command object bank.
// Assumes the design package is compiled first; the bench drives every port.
`timescale 1ns/1ns

module testbench;
   // ------------------------------------------------------------
   // ports of the design
   // ------------------------------------------------------------
   logic mclk = 1'b0; // 250 MHz bus clock
   logic rstn; // async, active low
   logic [7:0] regAddr, regWdata, regRdata;
   logic regWr, regRd;
   logic nvLoad, nvProtDbe, nvOptDbe;
   logic [7:0] nvProtByte, nvOptByte, optionBits;
   logic cmdLaunch, cmdDone, resWe, chkValid, chkBlkErase, chkDenied, irq;
   logic [2:0] resIdx;
   logic [15:0] resData;
   logic [23:0] chkAddr;
   nvm_protect_pkg::cmd_s cmdOut;
   nvm_protect_pkg::cmd_s expCmd; // what the launch should hand over
   int error_cnt = 0;
   int compares = 0;
   int cycles = 0; // hang guard
   // command words, distinct per byte so swaps show up
   logic [15:0] w [6] = '{16'h4210, 16'h00C0, 16'h1A2B, 16'h3C4D, 16'h5E6F, 16'h7081};

   always #2 mclk = ~mclk;

   nvm_protect_cmd_regs u_nvm_protect_cmd_regs (.mclk(mclk), .rstn(rstn), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .nvLoad(nvLoad),
      .nvProtByte(nvProtByte), .nvProtDbe(nvProtDbe), .nvOptByte(nvOptByte), .nvOptDbe(nvOptDbe),
      .cmdLaunch(cmdLaunch), .cmdOut(cmdOut), .cmdDone(cmdDone), .resWe(resWe), .resIdx(resIdx),
      .resData(resData), .chkValid(chkValid), .chkAddr(chkAddr), .chkBlkErase(chkBlkErase),
      .chkDenied(chkDenied), .optionBits(optionBits), .irq(irq));

   // ------------------------------------------------------------
   // checking and closing
   // ------------------------------------------------------------
   // wide enough for the whole command struct
   task automatic cmp(input logic [127:0] got, input logic [127:0] exp, input string what);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("FAIL %0t ns: %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask

   task automatic wrap_up;
      $display("compares %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // whole run is well under a thousand cycles
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         error_cnt++;
         $display("FAIL %0t ns: run did not finish", $time);
         wrap_up();
      end
   end

   // ------------------------------------------------------------
   // bus and side-port tasks
   // ------------------------------------------------------------
   // one-cycle write strobe, released after the taking edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string what);
      @(posedge mclk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge mclk);
      regRd <= 1'b0;
      #1;
      cmp(regRdata, e, what);
   endtask

   // one-edge check request; the answer is combinational
   task automatic prot(input logic [23:0] a, input logic blk, input logic e);
      @(posedge mclk);
      chkValid <= 1'b1;
      chkAddr <= a;
      chkBlkErase <= blk;
      #1;
      cmp(chkDenied, e, "check denied");
      @(posedge mclk);
      chkValid <= 1'b0;
   endtask

   // one load pulse from the reset loader
   task automatic nvl(input logic [7:0] p, input logic pf, input logic [7:0] o, input logic of);
      @(posedge mclk);
      nvLoad <= 1'b1;
      nvProtByte <= p;
      nvProtDbe <= pf;
      nvOptByte <= o;
      nvOptDbe <= of;
      @(posedge mclk);
      nvLoad <= 1'b0;
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      rstn = 1'b0;
      {regAddr, regWdata, regWr, regRd, nvLoad, nvProtDbe, nvOptDbe} = '0;
      {nvProtByte, nvOptByte, cmdDone, resWe, resIdx, resData} = '0;
      {chkValid, chkBlkErase, chkAddr} = '0;
      repeat (8) @(posedge mclk);
      rstn <= 1'b1;
      // defaults before the loader runs
      rd(8'h09, 8'h0F, "prot reset");
      rd(8'h0A, 8'hFF, "option reset");
      // loader; unused protection bits must not show
      nvl(8'hF3, 1'b0, 8'h5A, 1'b0);
      rd(8'h09, 8'h83, "prot loaded");
      rd(8'h0A, 8'h5A, "option loaded");
      cmp(optionBits, 8'h5A, "option pins");
      // read-only and reserved places ignore writes
      wr(8'h0A, 8'hFF);
      wr(8'h0B, 8'hFF);
      rd(8'h0A, 8'h5A, "option write");
      rd(8'h0B, 8'h00, "reserved");
      rd(8'h30, 8'h00, "unmapped");
      // disabled: nothing protected, block erase allowed
      prot(24'h10_0000, 1'b0, 1'b0);
      prot(24'h10_0000, 1'b1, 1'b0);
      // protection can only grow
      wr(8'h09, 8'h02);
      rd(8'h09, 8'h03, "shrink refused");
      wr(8'h09, 8'h85);
      rd(8'h09, 8'h05, "grow, no reopen");
      wr(8'h09, 8'h84);
      rd(8'h09, 8'h05, "shrink again");
      // size 5 covers 192 bytes from the base
      wr(8'h0F, 8'h03);
      prot(24'h10_00BF, 1'b0, 1'b1);
      prot(24'h10_00C0, 1'b0, 1'b0);
      prot(24'h0F_FFFF, 1'b0, 1'b0);
      prot(24'h10_0100, 1'b1, 1'b1);
      rd(8'h06, 8'hA0, "violation flag");
      rd(8'h0E, 8'h02, "irq status viol");
      cmp(irq, 1'b1, "irq raised");
      wr(8'h06, 8'h20);
      wr(8'h0E, 8'h02);
      rd(8'h06, 8'h80, "violation cleared");
      cmp(irq, 1'b0, "irq cleared");
      // loader faults force full protection and all option bits
      nvl(8'h83, 1'b1, 8'h00, 1'b1);
      rd(8'h09, 8'h0F, "prot fault");
      rd(8'h0A, 8'hFF, "option fault");
      cmp(optionBits, 8'hFF, "option pins fault");
      prot(24'h10_01FF, 1'b0, 1'b1);
      prot(24'h10_0200, 1'b0, 1'b0);
      wr(8'h06, 8'h20);
      wr(8'h0E, 8'h02);
      // load all six words bytewise and read them back
      for (int i = 0; i < 6; i++)
      begin
         wr(8'h02, 8'(i));
         wr(8'h0C, w[i][15:8]);
         wr(8'h0D, w[i][7:0]);
         rd(8'h0C, w[i][15:8], "word hi");
         rd(8'h0D, w[i][7:0], "word lo");
      end
      wr(8'h02, 8'h05);
      expCmd.code = w[0][15:8];
      expCmd.addr = {w[0][7:0], w[1]};
      for (int i = 0; i < 4; i++)
         expCmd.data[i] = w[i + 2];
      expCmd.words = 3'h5;
      wr(8'h06, 8'h80);
      #1;
      cmp(cmdLaunch, 1'b1, "launch pulse");
      cmp(cmdOut, expCmd, "command layout");
      rd(8'h06, 8'h00, "busy flag");
      cmp(cmdLaunch, 1'b0, "launch one cycle");
      // array locked while busy
      wr(8'h02, 8'h02);
      wr(8'h0C, 8'h55);
      wr(8'h0D, 8'h55);
      // controller returns a result, then finishes
      // result goes to word 3, so word 2 still shows whether the busy writes were dropped
      @(posedge mclk);
      resWe <= 1'b1;
      resIdx <= 3'h3;
      resData <= 16'hBEEF;
      @(posedge mclk);
      resWe <= 1'b0;
      cmdDone <= 1'b1;
      @(posedge mclk);
      cmdDone <= 1'b0;
      rd(8'h06, 8'h80, "done flag");
      rd(8'h0E, 8'h01, "irq status done");
      cmp(irq, 1'b1, "irq done");
      rd(8'h0C, w[2][15:8], "locked hi");
      rd(8'h0D, w[2][7:0], "locked lo");
      wr(8'h02, 8'h03);
      rd(8'h0C, 8'hBE, "result hi");
      rd(8'h0D, 8'hEF, "result lo");
      wr(8'h0F, 8'h02);
      #1;
      cmp(irq, 1'b0, "irq masked");
      wr(8'h0E, 8'h01);
      rd(8'h0E, 8'h00, "irq status clear");
      // controller strobes while idle are ignored
      @(posedge mclk);
      resWe <= 1'b1;
      resData <= 16'h1111;
      cmdDone <= 1'b1;
      @(posedge mclk);
      resWe <= 1'b0;
      cmdDone <= 1'b0;
      rd(8'h0C, 8'hBE, "result kept idle");
      rd(8'h0E, 8'h00, "done ignored idle");
      // index past the array: writes dropped, reads zero
      wr(8'h02, 8'h06);
      wr(8'h0C, 8'h77);
      rd(8'h0C, 8'h00, "index beyond array");
      // mid-run reset brings back the safe defaults
      @(posedge mclk);
      rstn <= 1'b0;
      @(posedge mclk);
      rstn <= 1'b1;
      rd(8'h02, 8'h00, "index after reset");
      rd(8'h06, 8'h80, "status after reset");
      rd(8'h09, 8'h0F, "prot after reset");
      wrap_up();
   end
endmodule
